// File: hdl/lcc_command.sv
// Command register of the network controller core: online control, transmit and remote DMA
//
// Behaviour
// - While the stop bit is set the core is offline and neither receives nor transmits.
// - A stop during a reception or transmission takes effect only after it has finished.
// - Reset is left only once the stop bit is clear and the go-online bit is set.
// - The software reset counts as done only when the reset-done flag reads 1.
// - The stop bit comes up set at power-up.
// - Writing stop while online leaves both stop and go-online set.
// - The go-online bit starts the core after power-up, software reset or error.
// - The go-online bit comes up cleared at power-up.
// - Transmit request clears itself when the transmission completes or aborts.
// - Writing the high remote DMA command bit aborts any remote DMA in progress.
// - An abort does not restore the remote start address; the host reloads it.
// - Command 000 is not allowed, 001 is remote read and 010 remote write.
// - Command 011 is send packet; any code with the high bit set aborts or completes.
// - The page bits pick register page 0, 1 or 2; code 11 is reserved.
`timescale 1ns/1ps
`include "lcc_params.svh"

module lcc_command
    import lcc_pkg::*;
#(
    parameter int ADDR_WIDTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic rx_busy,
    input wire logic tx_busy,
    input wire logic tx_done,
    input wire logic dma_done,
    input wire logic core_error,
    input wire logic reset_flag_clear,
    output logic reset_flag,
    output logic core_online,
    output logic transmit_request,
    output logic dma_read,
    output logic dma_write,
    output logic dma_send,
    output logic dma_abort,
    output logic [1:0] page_select
);

    if (ADDR_WIDTH < 4) begin : g_check
        $error("lcc_command: ADDR_WIDTH must be at least 4");
    end

    ////////////////////////////////////////////////////////////////////////////
    lcc_state_type state_q, state_d;
    logic stop_q, stop_d;
    logic go_q, go_d;
    logic txreq_q, txreq_d;
    logic [2:0] dma_cmd_q, dma_cmd_d;
    logic [1:0] page_q, page_d;
    logic flag_q, flag_d;
    logic abort_q, abort_d;
    logic rd_q, rd_d;
    logic wr_q, wr_d;
    logic send_q, send_d;
    logic online_q, online_d;
    logic [7:0] rdata_q, rdata_d;
    logic cmd_hit;
    logic cmd_wr;
    logic [2:0] wr_dma;

    assign cmd_hit = (reg_addr == ADDR_WIDTH'(`LCC_CMD_OFFSET));
    assign cmd_wr = reg_wr && cmd_hit;
    assign wr_dma = reg_wdata[`LCC_BIT_DMA_HI:`LCC_BIT_DMA_LO];

    always_comb begin
        state_d = state_q;
        stop_d = stop_q;
        go_d = go_q;
        txreq_d = txreq_q;
        dma_cmd_d = dma_cmd_q;
        page_d = page_q;
        flag_d = flag_q;
        abort_d = 1'b0;
        rdata_d = 8'h00;
        if (reg_rd && cmd_hit) begin
            rdata_d = {page_q, dma_cmd_q, txreq_q, go_q, stop_q};
        end
        if (reset_flag_clear) begin
            flag_d = 1'b0;
        end
        if (tx_done) begin
            txreq_d = 1'b0;
        end
        if (dma_done) begin
            dma_cmd_d = `LCC_DMA_ABORT;
        end
        if (cmd_wr) begin
            page_d = reg_wdata[`LCC_BIT_PAGE_HI:`LCC_BIT_PAGE_LO];
            stop_d = reg_wdata[`LCC_BIT_STOP];
            // Go bit sticks when stopping from start mode
            if (reg_wdata[`LCC_BIT_STOP] && state_q == LCC_ONLINE) begin
                go_d = 1'b1;
            end else begin
                go_d = reg_wdata[`LCC_BIT_GO];
            end
            // Writing zero has no effect once a transmission is requested
            if (reg_wdata[`LCC_BIT_TXREQ] && state_q == LCC_ONLINE
                && !reg_wdata[`LCC_BIT_STOP]) begin
                txreq_d = 1'b1;
            end
            if (wr_dma[2]) begin
                // Start address is left as is; host must reload it
                dma_cmd_d = wr_dma;
                abort_d = 1'b1;
            end else if (wr_dma != `LCC_DMA_NOT_ALLOWED) begin
                dma_cmd_d = wr_dma;
            end
        end
        case (state_q)
            LCC_OFFLINE: begin
                if (!stop_q && go_q && !core_error) begin
                    state_d = LCC_ONLINE;
                end
            end
            LCC_ONLINE: begin
                if (stop_q) begin
                    state_d = LCC_STOPPING;
                end
            end
            LCC_STOPPING: begin
                // Wait for the packet in flight
                if (!rx_busy && !tx_busy) begin
                    state_d = LCC_OFFLINE;
                end
            end
            default: begin
                state_d = LCC_OFFLINE;
            end
        endcase
        if (core_error && state_q != LCC_OFFLINE) begin
            state_d = LCC_OFFLINE;
            go_d = 1'b0;
        end
        // An error exit must not leave a request pending while offline
        if (state_d == LCC_OFFLINE) begin
            txreq_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (state_d == LCC_OFFLINE && state_q != LCC_OFFLINE) begin
            flag_d = 1'b1;
        end
        rd_d = (dma_cmd_d == `LCC_DMA_READ);
        wr_d = (dma_cmd_d == `LCC_DMA_WRITE);
        send_d = (dma_cmd_d == `LCC_DMA_SEND);
        // Drops with the stop write, not a cycle later with the state
        online_d = (state_d == LCC_ONLINE) && !stop_d;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= LCC_OFFLINE;
            stop_q <= 1'b1;
            go_q <= 1'b0;
            txreq_q <= 1'b0;
            dma_cmd_q <= `LCC_DMA_ABORT;
            page_q <= `LCC_PAGE_RESET;
            flag_q <= 1'b0;
            abort_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            send_q <= 1'b0;
            online_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            stop_q <= stop_d;
            go_q <= go_d;
            txreq_q <= txreq_d;
            dma_cmd_q <= dma_cmd_d;
            page_q <= page_d;
            flag_q <= flag_d;
            abort_q <= abort_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            send_q <= send_d;
            online_q <= online_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reset_flag = flag_q;
    assign core_online = online_q;
    assign transmit_request = txreq_q;
    assign dma_read = rd_q;
    assign dma_write = wr_q;
    assign dma_send = send_q;
    assign dma_abort = abort_q;
    assign page_select = page_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_OFFLINE_NO_TX: assert property (
        state_q == LCC_OFFLINE |-> !txreq_q && !core_online)
        else $error("transmit request seen while offline");
    AST_STOP_OFFLINE: assert property (
        stop_q |-> !core_online)
        else $error("core online while stop bit set");
    AST_STOP_WAITS: assert property (
        state_q == LCC_STOPPING && (rx_busy || tx_busy) && !core_error
        |=> state_q == LCC_STOPPING)
        else $error("reset entered during active packet");
    AST_STAY_RESET: assert property (
        state_q == LCC_OFFLINE && (stop_q || !go_q) |=> state_q == LCC_OFFLINE)
        else $error("left reset without stop clear and go set");
    AST_GO_STARTS: assert property (
        state_q == LCC_OFFLINE && !stop_q && go_q && !core_error
        |=> state_q == LCC_ONLINE ##0 core_online == !stop_q)
        else $error("go bit did not start core");
    AST_FLAG_ON_ENTRY: assert property (
        state_q == LCC_OFFLINE && $past(state_q) != LCC_OFFLINE |-> flag_q)
        else $error("reset-done flag not set on reset entry");
    AST_POWERUP_BITS: assert property (
        $fell(reset) |-> stop_q && !go_q)
        else $error("stop or go bit wrong after power-up");
    AST_STOP_KEEPS_GO: assert property (
        cmd_wr && reg_wdata[`LCC_BIT_STOP] && state_q == LCC_ONLINE && !core_error
        |=> stop_q && go_q ##1 state_q == LCC_STOPPING)
        else $error("stop in start mode did not keep both bits");
    AST_TX_CLEAR: assert property (
        tx_done && !(cmd_wr && reg_wdata[`LCC_BIT_TXREQ]) |=> !txreq_q)
        else $error("transmit request not cleared on done");
    AST_ABORT: assert property (
        cmd_wr && wr_dma[2] |=> abort_q && !rd_q && !wr_q && !send_q && dma_cmd_q[2])
        else $error("remote DMA abort not carried out");
    AST_NOT_ALLOWED: assert property (
        cmd_wr && wr_dma == `LCC_DMA_NOT_ALLOWED && !dma_done |=> $stable(dma_cmd_q))
        else $error("disallowed remote DMA code was taken");
    AST_DECODE: assert property (
        cmd_wr && wr_dma == `LCC_DMA_SEND && !dma_done |=> send_q && !rd_q && !wr_q)
        else $error("send packet code not decoded");
    AST_PAGE: assert property (
        cmd_wr |=> page_q == $past(reg_wdata[`LCC_BIT_PAGE_HI:`LCC_BIT_PAGE_LO]))
        else $error("page select not stored");

    COV_STOP_BUSY: cover property (
        state_q == LCC_STOPPING && tx_busy ##1 state_q == LCC_STOPPING);
    COV_RESTART: cover property (state_q == LCC_OFFLINE ##1 state_q == LCC_ONLINE);
    COV_ABORT: cover property (abort_q && $past(rd_q));
    COV_TX_DONE: cover property (txreq_q ##1 tx_done ##1 !txreq_q);

endmodule // lcc_command

// File: hdl/lcc_params.svh
// Offsets, bit positions and reset values of the command register block
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH
`define LCC_CMD_OFFSET 4'h0
`define LCC_BIT_STOP 0
`define LCC_BIT_GO 1
`define LCC_BIT_TXREQ 2
`define LCC_BIT_DMA_LO 3
`define LCC_BIT_DMA_HI 5
`define LCC_BIT_PAGE_LO 6
`define LCC_BIT_PAGE_HI 7
`define LCC_DMA_NOT_ALLOWED 3'h0
`define LCC_DMA_READ 3'h1
`define LCC_DMA_WRITE 3'h2
`define LCC_DMA_SEND 3'h3
`define LCC_DMA_ABORT 3'h4
`define LCC_PAGE_RESET 2'h0
`endif

// File: hdl/lcc_pkg.sv
// Types of the command register block
package lcc_pkg;
    // Gray coded along offline -> online -> stopping
    typedef enum logic [1:0] {
        LCC_OFFLINE  = 2'b00,
        LCC_ONLINE   = 2'b01,
        LCC_STOPPING = 2'b11
    } lcc_state_type;
endpackage

// File: tb/lcc_tx_engine.sv
// Transmit engine model: busy for a few cycles per request, then a done pulse
`timescale 1ns/1ps
module lcc_tx_engine #(
    parameter int TX_CYCLES = 6
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic transmit_request,
    output logic tx_busy,
    output logic tx_done
);
    int count_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= 0;
            tx_busy <= 1'b0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_busy) begin
                count_q <= count_q + 1;
                if (count_q == TX_CYCLES - 1) begin
                    tx_busy <= 1'b0;
                    tx_done <= 1'b1;
                end
            // Gap after done keeps a lingering request from relaunching
            end else if (transmit_request && !tx_done) begin
                count_q <= 0;
                tx_busy <= 1'b1;
            end
        end
    end
endmodule // lcc_tx_engine

// File: tb/lcc_command_tb_top.sv
// Register level tests of the command register block
`timescale 1ns/1ps
module lcc_command_tb_top;
    import lcc_pkg::*;
    logic clock = 0, reset = 1, reg_wr = 0, reg_rd = 0, rx_busy = 0, dma_done = 0;
    logic core_error = 0, reset_flag_clear = 0, tx_busy, tx_done, reset_flag, core_online;
    logic transmit_request, dma_read, dma_write, dma_send, dma_abort;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, rdv;
    logic [1:0] page_select;
    int failures = 0, samples_checked = 0, cycles = 0;
    logic [7:0] codes [4] = '{8'h0A, 8'h12, 8'h1A, 8'h3A};
    lcc_command lcc_command_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdv),
        .rx_busy(rx_busy), .tx_busy(tx_busy), .tx_done(tx_done), .dma_done(dma_done),
        .core_error(core_error), .reset_flag_clear(reset_flag_clear),
        .reset_flag(reset_flag), .core_online(core_online),
        .transmit_request(transmit_request), .dma_read(dma_read), .dma_write(dma_write),
        .dma_send(dma_send), .dma_abort(dma_abort), .page_select(page_select));
    lcc_tx_engine lcc_tx_engine_inst (.clock(clock), .reset(reset),
        .transmit_request(transmit_request), .tx_busy(tx_busy), .tx_done(tx_done));
    initial begin
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clock) begin
            reg_wr <= 1'b1;
            reg_wdata <= d;
        end
        @(posedge clock) reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] exp);
        @(posedge clock) reg_rd <= 1'b1;
        @(posedge clock) reg_rd <= 1'b0;
        #1 chk("command_control", exp, rdv);
    endtask
    // Selector 0 dma_done, 1 reset_flag_clear, 2 core_error
    task automatic pulse(input int which);
        @(posedge clock) begin
            dma_done <= (which == 0);
            reset_flag_clear <= (which == 1);
            core_error <= (which == 2);
        end
        @(posedge clock) begin
            dma_done <= 1'b0;
            reset_flag_clear <= 1'b0;
            core_error <= 1'b0;
        end
        #1;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rd(8'h21);
        chk("core_online", 8'h00, {7'h00, core_online});
        wr(8'h02);
        @(posedge clock) #1 chk("core_online", 8'h01, {7'h00, core_online});
        rd(8'h22);
        for (int i = 0; i < 4; i++) begin
            wr(codes[i]);
            chk("dma", {4'h0, i == 3, i == 2, i == 1, i == 0},
                {4'h0, dma_abort, dma_send, dma_write, dma_read});
        end
        wr(8'h0A);
        pulse(0);
        rd(8'h22);
        for (int p = 0; p < 4; p++) begin
            wr(8'h22 | 8'(p << 6));
            chk("page_select", 8'(p), {6'h00, page_select});
        end
        wr(8'h26);
        chk("transmit_request", 8'h01, {7'h00, transmit_request});
        repeat (2) @(posedge clock);
        wr(8'h21);
        chk("online_flag", 8'h00, {6'h00, reset_flag, core_online});
        for (int n = 0; n < 20 && reset_flag !== 1'b1; n++) @(posedge clock) #1;
        chk("tx_after_stop", 8'h01, {6'h00, transmit_request, reset_flag});
        rd(8'h23);
        pulse(1);
        chk("reset_flag", 8'h00, {7'h00, reset_flag});
        wr(8'h22); // go set again, DMA field left at the abort code
        @(posedge clock) #1 chk("core_online", 8'h01, {7'h00, core_online});
        pulse(2);
        rd(8'h20);
        wr(8'h22);
        @(posedge clock) #1 chk("core_online", 8'h01, {7'h00, core_online});
        pulse(1);
        @(posedge clock) rx_busy <= 1'b1;
        wr(8'h21);
        repeat (4) @(posedge clock);
        #1 chk("stop_rx_busy", 8'h00, {6'h00, reset_flag, core_online});
        @(posedge clock) rx_busy <= 1'b0;
        @(posedge clock) #1 chk("rx_done_flag", 8'h01, {7'h00, reset_flag});
        final_report();
    end
endmodule // lcc_command_tb_top
